/* File: src/angc_regs.sv */
/*
  Register bank: expansion status, next-page transmit and receive words,
  gigabit control with deferred advertisement fields.
  Assumes event inputs come from logic on ref_clk_in; strap pins are
  asynchronous and pass a two-stage synchroniser.
*/
// The implementer's own choice: the plain strobed port.
`default_nettype none
module angc_regs
  import angc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic sw_reset_in,
  input wire logic an_restart_in,
  input wire logic power_up_in,
  input wire logic link_fail_in,
  input wire logic an_complete_in,
  input wire logic par_fault_in,
  input wire logic page_rx_in,
  input wire logic [15:0] page_rx_word_in,
  input wire logic lp_np_able_in,
  input wire logic lp_an_able_in,
  input wire logic master_slave_strap_input,
  input wire logic gig_half_duplex_strap_input,
  input wire logic [4:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  output logic np_loaded_out,
  output logic [2:0] test_mode_out,
  output logic tx_clk_from_rx_out,
  output logic ms_manual_out,
  output logic ms_master_out,
  output logic port_multi_out,
  output logic adv_fd_out,
  output logic adv_hd_out
);
  logic [1:0] ms_sync_ff;  // Strap synchroniser
  logic [1:0] hd_sync_ff;
  logic strap_done_ff;  // Straps captured once after release
  // Counts out the synchroniser depth so the straps are not read as reset zeros
  logic [1:0] strap_wait_ff;
  logic pdf_ff, nxt_pdf;
  logic pr_ff, nxt_pr;
  logic [15:0] nptx_ff, nxt_nptx;
  logic np_loaded_ff, nxt_np_loaded;
  logic [15:0] lpnp_ff, nxt_lpnp;
  logic [15:0] gc_ff, nxt_gc;  // Software-visible control word
  logic [4:0] act_ff, nxt_act;  // Active copy of bits 12:8
  logic [15:0] rdata_ff, nxt_rdata;
  logic [15:0] exp_word;
  logic rd_exp, wr_np, wr_gc, apply;

  // Strap synchronisers; first stage read only by the second
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ms_sync_ff <= 2'h0;
      hd_sync_ff <= 2'h0;
    end else begin
      ms_sync_ff <= {ms_sync_ff[0], master_slave_strap_input};
      hd_sync_ff <= {hd_sync_ff[0], gig_half_duplex_strap_input};
    end
  end

  assign rd_exp = rd_in && (addr_in == ANGC_ADDR_EXP);
  assign wr_np = wr_in && (addr_in == ANGC_ADDR_NPTX);
  assign wr_gc = wr_in && (addr_in == ANGC_ADDR_GCTL);
  assign apply = sw_reset_in || an_restart_in || power_up_in || link_fail_in;

  // Expansion word as read
  always_comb begin
    exp_word = 16'h0000;  // reserved zero
    exp_word[ANGC_EXP_PDF] = pdf_ff;
    exp_word[ANGC_EXP_LPNP] = lp_np_able_in;
    exp_word[ANGC_EXP_LNP] = 1'b1;
    exp_word[ANGC_EXP_PR] = pr_ff;
    exp_word[ANGC_EXP_LPAN] = lp_an_able_in;
  end

  // Next-state logic for all register state except the strap synchronisers and capture counters
  always_comb begin
    // latch high, read clears, set wins
    nxt_pdf = par_fault_in | (pdf_ff & ~rd_exp);
    nxt_pr = page_rx_in | (pr_ff & ~rd_exp);
    if (sw_reset_in) begin
      nxt_pdf = 1'b0;
      nxt_pr = 1'b0;
    end
    nxt_nptx = nptx_ff;
    nxt_np_loaded = np_loaded_ff;
    if (link_fail_in) begin
      nxt_nptx = 16'h0000;
      nxt_np_loaded = 1'b0;
    end else if (sw_reset_in) begin
      nxt_nptx = ANGC_NPTX_RST;
      nxt_np_loaded = 1'b0;
    end else if (wr_np) begin
      // read-only bits 14 and 11 kept
      nxt_nptx = (wdata_in & ANGC_NPTX_WMASK) | (nptx_ff & ~ANGC_NPTX_WMASK);
      nxt_np_loaded = 1'b1;
    end
    nxt_lpnp = sw_reset_in ? ANGC_LPNP_RST : (page_rx_in ? page_rx_word_in : lpnp_ff);
    nxt_gc = gc_ff;
    if (!strap_done_ff) begin
      // straps load bits 11, 10 and 8
      nxt_gc[ANGC_GC_MSVAL] = ms_sync_ff[1];
      nxt_gc[ANGC_GC_PTYPE] = ms_sync_ff[1];
      nxt_gc[ANGC_GC_HD] = hd_sync_ff[1];
    end else if (wr_gc) begin
      // reserved low byte stored as written
      nxt_gc = wdata_in;
    end
    if (an_restart_in || sw_reset_in) begin
      nxt_gc[15:13] = ANGC_TM_NORMAL;
    end
    nxt_act = apply ? nxt_gc[12:8] : act_ff;
    if (!strap_done_ff) begin
      nxt_act = nxt_gc[12:8];
    end
    nxt_rdata = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        ANGC_ADDR_EXP: nxt_rdata = exp_word;
        ANGC_ADDR_NPTX: nxt_rdata = nptx_ff;
        ANGC_ADDR_LPNP: nxt_rdata = lpnp_ff;
        ANGC_ADDR_GCTL: nxt_rdata = gc_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  // Register stage; straps sampled in the clocked domain after release
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_done_ff <= 1'b0;
      strap_wait_ff <= 2'h0;
      pdf_ff <= 1'b0;
      pr_ff <= 1'b0;
      nptx_ff <= ANGC_NPTX_RST;
      np_loaded_ff <= 1'b0;
      lpnp_ff <= ANGC_LPNP_RST;
      // manual enable zero; full duplex one
      gc_ff <= ANGC_GCTL_RST;
      act_ff <= ANGC_GCTL_RST[12:8];
      rdata_ff <= 16'h0000;
    end else begin
      // Capture ends only once both synchroniser stages hold the pin value
      strap_wait_ff <= {strap_wait_ff[0], 1'b1};
      strap_done_ff <= strap_wait_ff[1];
      pdf_ff <= nxt_pdf;
      pr_ff <= nxt_pr;
      nptx_ff <= nxt_nptx;
      np_loaded_ff <= nxt_np_loaded;
      lpnp_ff <= nxt_lpnp;
      gc_ff <= nxt_gc;
      act_ff <= nxt_act;
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs to the negotiation engine
  assign rdata_out = rdata_ff;
  assign np_loaded_out = np_loaded_ff;
  assign test_mode_out = gc_ff[15:13];
  assign tx_clk_from_rx_out = (gc_ff[15:13] == ANGC_TM_JIT_M) || (gc_ff[15:13] == ANGC_TM_JIT_S);
  assign ms_manual_out = act_ff[4];
  assign ms_master_out = act_ff[3];
  assign port_multi_out = act_ff[4] ? 1'b0 : act_ff[2];
  assign adv_fd_out = act_ff[1];
  assign adv_hd_out = act_ff[0];
endmodule
`default_nettype wire

/* File: src/angc_pkg.sv */
/*
  Package for the auto-negotiation next-page and gigabit control register bank.
  Holds register offsets, field positions, reset values and test-mode codes.
  Assumes a plain register port and one 50 MHz clock domain.
*/
// Overview of operation
// - Expansion bits 15:5 always read zero
// - Expansion bits read the same before and after negotiation completes (an_complete_in unused)
// - Parallel fault flag latches high until read
// - Bit 3 shows partner next-page ability
// - Bit 2 local next-page able, resets one
// - Page received latches high, cleared by read
// - Bit 0 shows partner auto-negotiation ability
// - Next-page write sets page-loaded variable
// - Link failure clears next-page transmit word
// - Transmit word field layout and resets
// - Partner next-page word read-only, resets zero
// - Bits 15:13 select test mode
// - Jitter test modes use receive clock
// - Negotiation restart clears test mode
// - Bits 12:8 apply only on update events
// - Bit 12 manual master/slave, hardware reset zero
// - Bit 11 one master, zero slave
// - Bits 11,10 load master/slave strap
// - Bit 10 port-type preference
// - Port type ignored under manual configuration
// - Bit 8 half duplex, loads strap
`default_nettype none
package angc_pkg;
  localparam logic [4:0] ANGC_ADDR_EXP = 5'h06;
  localparam logic [4:0] ANGC_ADDR_NPTX = 5'h07;
  localparam logic [4:0] ANGC_ADDR_LPNP = 5'h08;
  localparam logic [4:0] ANGC_ADDR_GCTL = 5'h09;
  localparam logic [15:0] ANGC_NPTX_RST = 16'h2001;
  localparam logic [15:0] ANGC_NPTX_WMASK = 16'hB7FF;
  localparam logic [15:0] ANGC_LPNP_RST = 16'h0000;
  // Gigabit control before the straps land: full duplex on, rest zero
  localparam logic [15:0] ANGC_GCTL_RST = 16'h0200;
  localparam int ANGC_EXP_PDF = 4;
  localparam int ANGC_EXP_LPNP = 3;
  localparam int ANGC_EXP_LNP = 2;
  localparam int ANGC_EXP_PR = 1;
  localparam int ANGC_EXP_LPAN = 0;
  localparam int ANGC_GC_MSEN = 12;
  localparam int ANGC_GC_MSVAL = 11;
  localparam int ANGC_GC_PTYPE = 10;
  localparam int ANGC_GC_FD = 9;
  localparam int ANGC_GC_HD = 8;
  localparam logic [2:0] ANGC_TM_NORMAL = 3'h0;
  localparam logic [2:0] ANGC_TM_WAVE = 3'h1;
  localparam logic [2:0] ANGC_TM_JIT_M = 3'h2;
  localparam logic [2:0] ANGC_TM_JIT_S = 3'h3;
  localparam logic [2:0] ANGC_TM_DIST = 3'h4;
endpackage
`default_nettype wire

/* File: bench/angc_regs_checker.sv */
/*
  Checker for the register bank: relations between its ports over time.
  Assumes it is bound to every angc_regs instance on one clock.
*/
`default_nettype none
module angc_regs_checker
  import angc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic sw_reset_in,
  input wire logic an_restart_in,
  input wire logic power_up_in,
  input wire logic link_fail_in,
  input wire logic par_fault_in,
  input wire logic page_rx_in,
  input wire logic [4:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic np_loaded_out,
  input wire logic [2:0] test_mode_out,
  input wire logic tx_clk_from_rx_out,
  input wire logic ms_manual_out,
  input wire logic ms_master_out,
  input wire logic port_multi_out,
  input wire logic adv_fd_out,
  input wire logic adv_hd_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Status read with no new event, so latched flags must fall
  sequence s_rd_exp;
    rd_in && addr_in == ANGC_ADDR_EXP && !page_rx_in && !par_fault_in;
  endsequence
  chk_exp_zero: assert property (
    rd_in && addr_in == ANGC_ADDR_EXP |=> rdata_out[15:5] == 11'h000 && rdata_out[2])
    else $error("status reserved bits or local bit wrong");
  chk_latch_clear: assert property (
    s_rd_exp ##1 (!page_rx_in && !par_fault_in) ##1 s_rd_exp |=> !rdata_out[4] && !rdata_out[1])
    else $error("latched flags survive a read");
  chk_nxt_loaded: assert property (
    wr_in && addr_in == ANGC_ADDR_NPTX && !link_fail_in && !sw_reset_in |=> np_loaded_out)
    else $error("page loaded not set by write");
  chk_link_clear: assert property (
    link_fail_in && !wr_in |=> !np_loaded_out)
    else $error("link failure left page loaded");
  chk_jitter_clk: assert property (
    tx_clk_from_rx_out == (test_mode_out == ANGC_TM_JIT_M || test_mode_out == ANGC_TM_JIT_S))
    else $error("transmit clock source wrong");
  chk_restart_mode: assert property (
    an_restart_in && !wr_in |=> test_mode_out == ANGC_TM_NORMAL)
    else $error("restart left a test mode");
  chk_port_ignored: assert property (
    ms_manual_out |-> !port_multi_out)
    else $error("port type used under manual setting");
  chk_adv_held: assert property (
    wr_in && !(sw_reset_in || an_restart_in || power_up_in || link_fail_in)
    |=> $stable({ms_manual_out, ms_master_out, port_multi_out, adv_fd_out, adv_hd_out}))
    else $error("advertisement changed without event");
  chk_rdata_idle: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data outside read cycle");
endmodule
bind angc_regs angc_regs_checker i_angc_regs_checker (.ref_clk_in, .rst_b_in, .sw_reset_in,
  .an_restart_in, .power_up_in, .link_fail_in, .par_fault_in, .page_rx_in, .addr_in, .wr_in,
  .rd_in, .rdata_out, .np_loaded_out, .test_mode_out, .tx_clk_from_rx_out, .ms_manual_out,
  .ms_master_out, .port_multi_out, .adv_fd_out, .adv_hd_out);
`default_nettype wire

/* File: bench/angc_partner.sv */
/*
  Link partner model: delivers one page with a fault and ability levels.
  Assumes the bench clock; the word is only valid beside its strobe.
*/
`default_nettype none
module angc_partner (
  input wire logic ref_clk_in,
  output logic par_fault_out,
  output logic page_rx_out,
  output logic [15:0] page_word_out,
  output logic np_able_out,
  output logic an_able_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {par_fault_out, page_rx_out, np_able_out, an_able_out} = 4'h0;
    page_word_out = 16'hA5C3;
  end
  task automatic send(input logic [15:0] w);
    @(posedge ref_clk_in);
    {page_rx_out, par_fault_out, np_able_out, an_able_out} <= 4'hF;
    page_word_out <= w;
    @(posedge ref_clk_in);
    {page_rx_out, par_fault_out} <= 2'b00;
    // Inverted so a late sample of the word is caught
    page_word_out <= ~w;
  endtask
endmodule
`default_nettype wire

/* File: bench/angc_regs_bench.sv */
/*
  Bench for the register bank: bus and event tasks, scenarios run in one initial block.
  Assumes the checker is bound from its own file.
*/
`default_nettype none
`define CMP(n, e, s) begin compares++; if ((s) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module angc_regs_bench
  import angc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in, rst_b_in, sw_reset_in, an_restart_in, power_up_in, link_fail_in;
  logic an_complete_in, par_fault_in, page_rx_in, lp_np_able_in, lp_an_able_in, wr_in, rd_in;
  logic master_slave_strap_input, gig_half_duplex_strap_input, np_loaded_out;
  logic tx_clk_from_rx_out, ms_manual_out, ms_master_out, port_multi_out, adv_fd_out, adv_hd_out;
  logic [15:0] page_rx_word_in, wdata_in, rdata_out;
  logic [4:0] addr_in;
  logic [2:0] test_mode_out;
  logic [3:0] evt_q;
  int err_count, compares;
  assign {link_fail_in, power_up_in, an_restart_in, sw_reset_in} = evt_q;
  angc_regs i_angc_regs (.ref_clk_in, .rst_b_in, .sw_reset_in, .an_restart_in, .power_up_in,
    .link_fail_in, .an_complete_in, .par_fault_in, .page_rx_in, .page_rx_word_in,
    .lp_np_able_in, .lp_an_able_in, .master_slave_strap_input, .gig_half_duplex_strap_input,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .np_loaded_out, .test_mode_out,
    .tx_clk_from_rx_out, .ms_manual_out, .ms_master_out, .port_multi_out, .adv_fd_out,
    .adv_hd_out);
  angc_partner i_angc_partner (.ref_clk_in, .par_fault_out(par_fault_in),
    .page_rx_out(page_rx_in), .page_word_out(page_rx_word_in), .np_able_out(lp_np_able_in),
    .an_able_out(lp_an_able_in));
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge ref_clk_in);
    {addr_in, rd_in} <= {a, 1'b1};
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 `CMP("rdata", e, rdata_out)
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk_in);
    evt_q <= m;
    @(posedge ref_clk_in);
    evt_q <= 4'h0;
    #1;
  endtask
  task automatic print_verdict();
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {rst_b_in, wr_in, rd_in, evt_q, addr_in, wdata_in, an_complete_in} = '0;
    {master_slave_strap_input, gig_half_duplex_strap_input} = 2'b10;
    repeat (16) @(posedge ref_clk_in);
    {rst_b_in, an_complete_in} <= 2'b11;
    repeat (2) @(posedge ref_clk_in);
    rd(ANGC_ADDR_EXP, 16'h0004);
    rd(ANGC_ADDR_LPNP, 16'h0000);
    rd(ANGC_ADDR_GCTL, 16'h0E00);
    rd(5'h0A, 16'h0000);
    `CMP("adv", 5'b01110, {ms_manual_out, ms_master_out, port_multi_out, adv_fd_out, adv_hd_out})
    wr(ANGC_ADDR_NPTX, 16'hFFFF);
    rd(ANGC_ADDR_NPTX, 16'hB7FF);
    `CMP("loaded", 1'b1, np_loaded_out)
    pulse(4'h8);
    rd(ANGC_ADDR_NPTX, 16'h0000);
    i_angc_partner.send(16'h5A5A);
    wr(ANGC_ADDR_LPNP, 16'hFFFF);
    rd(ANGC_ADDR_LPNP, 16'h5A5A);
    rd(ANGC_ADDR_EXP, 16'h001F);
    rd(ANGC_ADDR_EXP, 16'h000D);
    wr(ANGC_ADDR_GCTL, 16'h1600);
    rd(ANGC_ADDR_GCTL, 16'h1600);
    `CMP("held", 5'b01110, {ms_manual_out, ms_master_out, port_multi_out, adv_fd_out, adv_hd_out})
    pulse(4'h4);
    `CMP("apply", 5'b10010, {ms_manual_out, ms_master_out, port_multi_out, adv_fd_out, adv_hd_out})
    for (int m = 0; m < 5; m++) begin
      wr(ANGC_ADDR_GCTL, {m[2:0], 13'h1600});
      `CMP("mode", m[2:0], test_mode_out)
      `CMP("txclk", (m == 2 || m == 3), tx_clk_from_rx_out)
    end
    pulse(4'h2);
    `CMP("mode", ANGC_TM_NORMAL, test_mode_out)
    pulse(4'h1);
    rd(ANGC_ADDR_NPTX, 16'h2001);
    rd(ANGC_ADDR_GCTL, 16'h1600);
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
